/* File: logic/drc_ctrl.sv */
// dram access sequencer for banks in burst page or normal mode, with edo cas timing
// assumes a core-side requester on clk and dram devices on the far pins
//
// Contract
// [R1] burst whenever operand size exceeds the addressed bank's port width; a bank with its burst bit clear opens a row per beat instead
// [R2] page-mode beats inside a burst, ras negated after the final beat
// [R3] no page-miss handling needed in burst page mode
// [R4] nonburst access runs like normal mode, ras negated at its end
// [R5] reads and writes share control timing, only data drive differs
// [R6] fastest burst: first beat three clocks, each later beat two
// [R7] fastest nonburst takes three clocks; timing register slows waveforms
// [R8] first high phase: row address, write strobe, size, transfer start
// [R9] size code 0 for longword, 2 for word, with the row address
// [R10] ras in first low phase; next high: start off, column, write data
// [R11] cas for accessed lanes in the low phase after column drive
// [R12] acknowledge in third clock, negated next clock with cas
// [R13] between beats keep ras, drop cas, drive next column and data
// [R14] burst end drops ack, ras, cas together, then releases data bus; here doe drops in that same clock
// [R15] next access starts two clocks after the clock ending a burst
// [R16] nonburst read data captured at edge after ack, then all negated
// [R17] one edo enable bit covers both banks; 1 enables it
// [R18] edo set: cas negates half a clock earlier on page-mode beats
// [R19] fastest page timing: one clock cas precharge with edo, half without
// [R20] software keeps edo dram out of fast page mode
module drc_ctrl
    import drc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic req_valid,
    input wire drc_req_s req,
    output logic req_ready,
    output logic rsp_valid,
    output drc_rsp_s rsp,
    input wire logic [31:0] dram_din,
    output drc_pins_s dram,
    output logic bus_clk
);
    // ==========================================================
    // state
    typedef struct packed {
        drc_state_e st;
        logic [3:0] cnt;
        logic [4:0] beats;
        logic [27:0] cur;
        logic wr;
        logic [1:0] size;
        logic [2:0] eb;
        logic [1:0] pmask;
        logic burst;
        logic bank;
        logic [127:0] wsh;
        logic [127:0] rsh;
        logic [1:0] cap_p;
        logic cap_last;
        logic [1:0] cap_off;
        logic [6:0] timing;
        logic [5:0] bankcfg;
        logic ready;
        logic rsp_valid;
        logic [127:0] rdata;
        logic [31:0] reg_rdata;
        drc_pins_s pins;
        logic bus_clk;
    } drc_core_s;

    drc_core_s s_r;
    drc_core_s s_nxt;
    logic phase_h;
    logic [31:0] din_sync;

    drc_phase u_phase (
        .clk(clk),
        .rst(rst),
        .phase_h(phase_h)
    );

    drc_sync u_sync (
        .clk(clk),
        .rst(rst),
        .d(dram_din),
        .q(din_sync)
    );

    assign reg_rdata = s_r.reg_rdata;
    assign req_ready = s_r.ready;
    assign rsp_valid = s_r.rsp_valid;
    assign rsp.rdata = s_r.rdata;
    assign dram = s_r.pins;
    assign bus_clk = s_r.bus_clk;

    // ==========================================================
    // next state
    always_comb begin
        logic go_row;
        logic edo_en;
        logic [3:0] rcd_ph;
        logic [3:0] cas_ph;
        logic [3:0] rp_ph;
        logic [2:0] ol;
        logic [2:0] pl;
        logic [1:0] port;
        logic breq;
        logic [27:0] nxt_addr;
        logic [127:0] nxt_wsh;
        logic [1:0] off;
        logic [31:0] beat_val;
        logic [127:0] rsh_new;
        go_row = 1'b0;
        edo_en = s_r.timing[DRC_TIM_EDO_BIT];
        rcd_ph = 4'(s_r.timing[DRC_TIM_RCD_LSB +: 2]) * DRC_PHASES_PER_CLK;
        cas_ph = 4'(s_r.timing[DRC_TIM_CAS_LSB +: 2]) * DRC_PHASES_PER_CLK;
        rp_ph = 4'(s_r.timing[DRC_TIM_RP_LSB +: 2]) * DRC_PHASES_PER_CLK;
        breq = req.addr[DRC_BANK_ADDR_BIT];
        port = s_r.bankcfg[DRC_BANK_FLD_W * breq +: 2];
        ol = drc_op_log2(req.size);
        pl = drc_port_log2(port);
        nxt_addr = s_r.cur + 28'(s_r.eb);
        nxt_wsh = s_r.wsh << {s_r.eb, 3'b000};
        // lanes follow the port width, so a narrow operand on a wide port lands on its own lanes
        off = s_r.cur[1:0] & s_r.pmask;
        beat_val = (din_sync << {s_r.cap_off, 3'b000}) >> {3'(3'h4 - s_r.eb), 3'b000};
        rsh_new = (s_r.rsh << {s_r.eb, 3'b000}) | {96'h0, beat_val};
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.reg_rdata = 32'h0;
        s_nxt.bus_clk = ~phase_h;

        // register port
        if (reg_we) begin
            case (reg_addr)
                DRC_OFS_TIMING: s_nxt.timing = reg_wdata[DRC_TIM_W-1:0]; // [R17]
                DRC_OFS_BANKCFG: s_nxt.bankcfg = reg_wdata[DRC_BANKCFG_W-1:0];
                default: s_nxt.timing = s_r.timing;
            endcase
        end
        if (reg_re) begin
            case (reg_addr)
                DRC_OFS_TIMING: s_nxt.reg_rdata = {25'h0, s_r.timing};
                DRC_OFS_BANKCFG: s_nxt.reg_rdata = {26'h0, s_r.bankcfg};
                DRC_OFS_STATUS: s_nxt.reg_rdata = {25'h0, ~&s_r.pins.ras_n, s_r.beats, s_r.st != ST_IDLE};
                default: s_nxt.reg_rdata = 32'h0;
            endcase
        end

        // accept a request; operand size against the bank's port width decides beats and bytes per beat
        if (req_valid && s_r.ready) begin
            s_nxt.cur = req.addr;
            s_nxt.wr = req.wr;
            s_nxt.size = req.size;
            s_nxt.bank = breq;
            s_nxt.wsh = req.wdata;
            s_nxt.rsh = 128'h0;
            s_nxt.pmask = 2'((3'h1 << pl) - 3'h1); // [R11]
            if (ol > pl) begin
                s_nxt.beats = 5'h01 << (ol - pl); // [R1]
                s_nxt.eb = 3'h1 << pl;
                s_nxt.burst = s_r.bankcfg[DRC_BANK_FLD_W * breq + DRC_BANK_BURST_BIT]; // [R2]
            end else begin
                s_nxt.beats = 5'h01;
                s_nxt.eb = 3'h1 << ol;
                s_nxt.burst = 1'b0; // [R4]
            end
        end

        // read capture, two phases after the beat-ending edge through the synchroniser
        s_nxt.cap_p = {s_r.cap_p[0], 1'b0};
        if (s_r.cap_p[1]) begin
            s_nxt.rsh = rsh_new; // [R16]
            if (s_r.cap_last) begin
                s_nxt.rsp_valid = 1'b1;
                s_nxt.rdata = rsh_new;
            end
        end

        case (s_r.st)
            ST_IDLE: begin
                // row phase must land on a high phase
                if (s_r.beats != 5'h0 && !phase_h) go_row = 1'b1;
            end
            ST_ROW: begin
                s_nxt.pins.ras_n[s_r.bank] = 1'b0; // [R10]
                s_nxt.cnt = rcd_ph; // [R7]
                s_nxt.st = ST_RAS;
            end
            ST_RAS: begin
                if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    s_nxt.pins.transfer_start_n = 1'b1; // [R10]
                    s_nxt.pins.addr = {10'h0, s_r.cur[8:0]};
                    s_nxt.pins.dout = drc_lane_data(s_r.wsh[127:96], s_r.eb);
                    s_nxt.pins.doe = s_r.wr; // [R5]
                    s_nxt.st = ST_COL;
                end
            end
            ST_COL: begin
                s_nxt.pins.cas_n = ~drc_lane_mask(s_r.eb, off); // [R11]
                s_nxt.cnt = cas_ph; // [R7]
                s_nxt.st = ST_CAS;
            end
            ST_CAS: begin
                if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    s_nxt.pins.xfer_ack = 1'b1; // [R12]
                    s_nxt.st = ST_ACK;
                end
            end
            ST_ACK: begin
                // edo keeps read data valid, so cas can start precharge half a clock early
                if (edo_en && s_r.burst) s_nxt.pins.cas_n = 4'hf; // [R18] [R19]
                s_nxt.st = ST_ACKL;
            end
            ST_ACKL: begin
                s_nxt.pins.xfer_ack = 1'b0; // [R12]
                s_nxt.pins.cas_n = 4'hf; // [R19]
                s_nxt.beats = s_r.beats - 5'h1;
                s_nxt.cur = nxt_addr;
                s_nxt.wsh = nxt_wsh;
                if (!s_r.wr) begin
                    s_nxt.cap_p[0] = 1'b1; // [R16]
                    s_nxt.cap_last = (s_r.beats == 5'h1);
                    s_nxt.cap_off = off;
                end else if (s_r.beats == 5'h1) begin
                    s_nxt.rsp_valid = 1'b1;
                end
                if (s_r.beats != 5'h1 && s_r.burst) begin
                    // later beats sit in the open page, so no row compare is kept
                    s_nxt.pins.addr = {10'h0, nxt_addr[8:0]}; // [R13] [R3]
                    s_nxt.pins.dout = drc_lane_data(nxt_wsh[127:96], s_r.eb); // [R13]
                    s_nxt.st = ST_COL; // [R6]
                end else begin
                    s_nxt.pins.ras_n = 2'b11; // [R2] [R4] [R14]
                    s_nxt.pins.doe = 1'b0; // [R14]
                    s_nxt.cnt = DRC_PRE_CNT + rp_ph; // [R15]
                    s_nxt.st = ST_PRE;
                end
            end
            ST_PRE: begin
                if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else if (s_r.beats != 5'h0) begin
                    go_row = 1'b1; // [R15]
                end else begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        if (go_row) begin
            s_nxt.pins.addr = s_r.cur[27:9]; // [R8]
            s_nxt.pins.dram_write_strobe_n = ~s_r.wr; // [R8]
            s_nxt.pins.transfer_size = s_r.size; // [R9]
            s_nxt.pins.transfer_start_n = 1'b0; // [R8]
            s_nxt.st = ST_ROW;
        end

        // a capture in flight still owns the read shifter
        s_nxt.ready = (s_nxt.st == ST_IDLE || s_nxt.st == ST_PRE) && s_nxt.beats == 5'h0 && s_nxt.cap_p == 2'b00;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.timing <= DRC_TIM_RST;
            s_r.bankcfg <= DRC_BANKCFG_RST;
            s_r.pins.ras_n <= 2'b11;
            s_r.pins.cas_n <= 4'hf;
            s_r.pins.transfer_start_n <= 1'b1;
            s_r.pins.dram_write_strobe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

/* File: logic/drc_phase.sv */
// bus clock phase divider: high phase and low phase alternate each clk cycle
// assumes reset releases into the high phase
module drc_phase
    import drc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    output logic phase_h
);
    // ==========================================================
    // divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_h <= 1'b1;
        end else begin
            phase_h <= ~phase_h;
        end
    end
endmodule

/* File: logic/drc_pkg.sv */
// constants, types and helpers shared by the dram burst-page sequencer
// assumes one 125 mhz clock; one dram bus clock spans two such cycles (high, low)
package drc_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] DRC_OFS_TIMING = 8'h00;
    localparam logic [7:0] DRC_OFS_BANKCFG = 8'h04;
    localparam logic [7:0] DRC_OFS_STATUS = 8'h08;
    localparam int DRC_TIM_EDO_BIT = 0;
    localparam int DRC_TIM_RCD_LSB = 1;
    localparam int DRC_TIM_CAS_LSB = 3;
    localparam int DRC_TIM_RP_LSB = 5;
    localparam int DRC_TIM_W = 7;
    localparam logic [6:0] DRC_TIM_RST = 7'h00;
    localparam int DRC_BANK_FLD_W = 3;
    localparam int DRC_BANK_BURST_BIT = 2;
    localparam int DRC_BANKCFG_W = 6;
    localparam logic [5:0] DRC_BANKCFG_RST = 6'h24;
    localparam int DRC_BANK_ADDR_BIT = 27;

    // ==========================================================
    // codes
    localparam logic [1:0] DRC_SZ_LONG = 2'h0;
    localparam logic [1:0] DRC_SZ_BYTE = 2'h1;
    localparam logic [1:0] DRC_SZ_WORD = 2'h2;
    localparam logic [1:0] DRC_SZ_LINE = 2'h3;
    localparam logic [1:0] DRC_PORT_32 = 2'h0;
    localparam logic [1:0] DRC_PORT_8 = 2'h1;
    localparam logic [1:0] DRC_PORT_16 = 2'h2;

    // ==========================================================
    // timing, in phases of the fast clock (two phases per bus clock)
    localparam int DRC_CLK_PERIOD_NS = 8;
    localparam logic [3:0] DRC_PHASES_PER_CLK = 4'h2;
    localparam int DRC_RP_MIN_CLKS = 2;
    localparam logic [3:0] DRC_PRE_CNT = 4'((DRC_RP_MIN_CLKS * 2) - 1);

    typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_RAS, ST_COL, ST_CAS, ST_ACK, ST_ACKL, ST_PRE} drc_state_e;

    typedef struct packed {
        logic [27:0] addr;
        logic wr;
        logic [1:0] size;
        logic [127:0] wdata;
    } drc_req_s;

    typedef struct packed {
        logic [127:0] rdata;
    } drc_rsp_s;

    typedef struct packed {
        logic [18:0] addr;
        logic transfer_start_n;
        logic dram_write_strobe_n;
        logic [1:0] transfer_size;
        logic [1:0] ras_n;
        logic [3:0] cas_n;
        logic [31:0] dout;
        logic doe;
        logic xfer_ack;
    } drc_pins_s;

    // ==========================================================
    // helpers
    function automatic logic [2:0] drc_op_log2(logic [1:0] sz);
        case (sz)
            DRC_SZ_BYTE: drc_op_log2 = 3'h0;
            DRC_SZ_WORD: drc_op_log2 = 3'h1;
            DRC_SZ_LONG: drc_op_log2 = 3'h2;
            default: drc_op_log2 = 3'h4;
        endcase
    endfunction

    function automatic logic [2:0] drc_port_log2(logic [1:0] p);
        case (p)
            DRC_PORT_8: drc_port_log2 = 3'h0;
            DRC_PORT_16: drc_port_log2 = 3'h1;
            default: drc_port_log2 = 3'h2;
        endcase
    endfunction

    // lane 0 is d[31:24] and pairs with cas bit 0
    function automatic logic [3:0] drc_lane_mask(logic [2:0] eb, logic [1:0] off);
        logic [3:0] m;
        m = 4'hf;
        if (eb == 3'h1) m = 4'h1;
        else if (eb == 3'h2) m = 4'h3;
        drc_lane_mask = m << off;
    endfunction

    // narrow operands are copied onto every lane so any port position sees them
    function automatic logic [31:0] drc_lane_data(logic [31:0] top, logic [2:0] eb);
        if (eb == 3'h1) drc_lane_data = {4{top[31:24]}};
        else if (eb == 3'h2) drc_lane_data = {2{top[31:16]}};
        else drc_lane_data = top;
    endfunction

endpackage

/* File: logic/drc_sync.sv */
// two-stage synchroniser for the dram read data pins
// assumes the pins change asynchronously to clk
module drc_sync
    import drc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] d,
    output logic [31:0] q
);
    // ==========================================================
    // stages
    logic [31:0] meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 32'h0;
            q <= 32'h0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* File: tb/drc_ctrl_checker.sv */
// checker: dram pin sequencing of the burst-page controller
// assumes binding onto drc_ctrl, timing fields other than edo left at zero
module drc_ctrl_checker
    import drc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire drc_pins_s dram
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic ras_off;
    logic st;
    assign ras_off = &dram.ras_n;
    assign st = dram.transfer_start_n;
    // ==========================================================
    // access opening
    property p_start_two;
        $fell(st) |=> !st ##1 st;
    endproperty
    a_start_two: assert property (p_start_two) else $error("start strobe not one bus clock");
    property p_ras_row;
        $fell(st) |=> dram.ras_n != 2'h3;
    endproperty
    a_ras_row: assert property (p_ras_row) else $error("row strobe late");
    property p_cas_col;
        $fell(st) |-> ##2 dram.cas_n == 4'hf ##1 dram.cas_n != 4'hf;
    endproperty
    a_cas_col: assert property (p_cas_col) else $error("column strobe misplaced");
    property p_ack_third;
        $fell(st) |-> ##4 $rose(dram.xfer_ack);
    endproperty
    a_ack_third: assert property (p_ack_third) else $error("acknowledge not in third clock");
    property p_ack_cas;
        $rose(dram.xfer_ack) |=> dram.xfer_ack ##1 (!dram.xfer_ack && dram.cas_n == 4'hf);
    endproperty
    a_ack_cas: assert property (p_ack_cas) else $error("acknowledge and cas not dropped together");
    // ==========================================================
    // data drive and close
    property p_wr_data;
        $fell(st) && !dram.dram_write_strobe_n |-> ##2 dram.doe;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not driven");
    property p_rd_float;
        $fell(st) && dram.dram_write_strobe_n |-> !dram.doe [*6];
    endproperty
    a_rd_float: assert property (p_rd_float) else $error("data driven on a read");
    property p_ras_end;
        $rose(ras_off) |-> dram.cas_n == 4'hf && !dram.xfer_ack && !dram.doe;
    endproperty
    a_ras_end: assert property (p_ras_end) else $error("close not simultaneous");
    property p_precharge;
        $rose(ras_off) |-> st [*4];
    endproperty
    a_precharge: assert property (p_precharge) else $error("precharge too short");
    c_burst: cover property ($rose(dram.xfer_ack) ##4 $rose(dram.xfer_ack));
    c_write: cover property ($fell(st) && !dram.dram_write_strobe_n);
    c_read: cover property ($fell(st) && dram.dram_write_strobe_n);
endmodule

bind drc_ctrl drc_ctrl_checker u_drc_ctrl_checker (.clk(clk), .rst(rst), .dram(dram));

/* File: tb/drc_ctrl_test.sv */
// testbench: burst-page and edo sequencing of drc_ctrl against a dram model
// assumes the checker file binds itself onto drc_ctrl
module drc_ctrl_test
    import drc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, req_valid = 1'b0, edo = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, dram_din;
    logic req_ready, rsp_valid, bus_clk, st_p = 1'b1, ack_p = 1'b0, st_wn;
    logic [1:0] st_size;
    logic st_bc;
    logic [18:0] st_row;
    logic [3:0] ack_cas;
    logic [127:0] rd;
    logic [31:0] wq [$];
    drc_req_s req = '0;
    drc_rsp_s rsp;
    drc_pins_s dram;
    int n_mismatch = 0, n_tests = 0, acks, gap, ras_len;
    always #4 clk = ~clk;
    drc_ctrl u_drc_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .dram_din(dram_din), .dram(dram), .bus_clk(bus_clk));
    drc_dram_model u_drc_dram_model (.clk(clk), .edo(edo), .dram(dram), .dram_din(dram_din));
    // ==========================================================
    // pin monitor: beats, row-open length, cas precharge after first beat
    always @(posedge clk) begin
        st_p <= dram.transfer_start_n;
        ack_p <= dram.xfer_ack;
        if (dram.ras_n != 2'h3) ras_len <= ras_len + 1;
        if (dram.ras_n != 2'h3 && dram.cas_n == 4'hf && acks > 0) gap <= gap + 1;
        if (dram.xfer_ack && !ack_p) begin
            acks <= acks + 1;
            ack_cas <= dram.cas_n;
            wq.push_back(dram.dout);
        end
        if (st_p && !dram.transfer_start_n) begin
            st_size <= dram.transfer_size;
            st_wn <= dram.dram_write_strobe_n;
            st_bc <= bus_clk;
            st_row <= dram.addr;
            acks <= 0;
            gap <= 0;
            ras_len <= 0;
        end
    end
    // ==========================================================
    // shared tasks
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a, logic [31:0] exp);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        @(posedge clk);
        chk("reg_rdata", exp, reg_rdata);
    endtask
    // reads of pins and handshakes happen before this edge's updates land
    task automatic access(logic [27:0] a, logic w, logic [1:0] sz, logic [127:0] wd);
        int i;
        wq.delete();
        req <= '{addr: a, wr: w, size: sz, wdata: wd};
        req_valid <= 1'b1;
        i = 0;
        do begin @(posedge clk); i++; end while (req_ready !== 1'b1 && i < 60);
        req_valid <= 1'b0;
        do begin @(posedge clk); i++; end while (rsp_valid !== 1'b1 && i < 260);
        if (rsp_valid !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
        rd = rsp.rdata;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        reg_rd(DRC_OFS_TIMING, 32'(DRC_TIM_RST));
        reg_rd(DRC_OFS_BANKCFG, 32'(DRC_BANKCFG_RST));
        reg_rd(8'h0c, 32'h0);
        reg_rd(DRC_OFS_STATUS, 32'h0);
    endtask
    task automatic t_write_long();
        reg_wr(DRC_OFS_BANKCFG, 32'h26);
        access(28'h0000010, 1'b1, DRC_SZ_LONG, {32'h1234abcd, 96'h0});
        chk("size", 128'(DRC_SZ_LONG), 128'(st_size));
        chk("write_strobe", 128'h0, 128'(st_wn));
        chk("beats", 128'h2, 128'(acks));
        chk("ras_len", 128'h9, 128'(ras_len));
        chk("cas_gap", 128'h1, 128'(gap));
        chk("beat0", 128'h12341234, 128'(wq[0]));
        chk("beat1", 128'habcdabcd, 128'(wq[1]));
    endtask
    task automatic t_read_word();
        access(28'h0000010, 1'b0, DRC_SZ_WORD, 128'h0);
        chk("size", 128'(DRC_SZ_WORD), 128'(st_size));
        chk("write_strobe", 128'h1, 128'(st_wn));
        chk("beats", 128'h1, 128'(acks));
        chk("ras_len", 128'h5, 128'(ras_len));
        chk("rdata", 128'h1234, 128'(rd[15:0]));
        access(28'h0000012, 1'b0, DRC_SZ_WORD, 128'h0);
        chk("rdata", 128'habcd, 128'(rd[15:0]));
    endtask
    // early cas must lengthen precharge yet keep the read data good
    task automatic t_edo();
        for (int e = 0; e < 2; e++) begin
            reg_wr(DRC_OFS_TIMING, 32'(e));
            edo <= e[0];
            @(posedge clk);
            access(28'h0000010, 1'b0, DRC_SZ_LONG, 128'h0);
            chk("rdata", 128'h1234abcd, 128'(rd[31:0]));
            chk("cas_gap", 128'(e ? 3 : 1), 128'(gap));
            chk("ras_len", 128'h9, 128'(ras_len));
        end
    endtask
    // last entry is a normal-mode bank: each beat opens its own row, so only one beat follows the last start
    task automatic t_beats();
        logic [5:0] cfg [5] = '{6'h25, 6'h24, 6'h24, 6'h25, 6'h21};
        logic [27:0] adr [5] = '{28'h20, 28'h20, 28'h8000020, 28'h8000024, 28'h20};
        logic [1:0] sz [5] = '{DRC_SZ_LONG, DRC_SZ_WORD, DRC_SZ_LINE, DRC_SZ_WORD, DRC_SZ_LONG};
        int nb [5] = '{4, 1, 4, 1, 1};
        for (int k = 0; k < 5; k++) begin
            reg_wr(DRC_OFS_BANKCFG, 32'(cfg[k]));
            access(adr[k], 1'b0, sz[k], 128'h0);
            chk("beats", 128'(nb[k]), 128'(acks));
            chk("ras_len", 128'(4 * nb[k] + 1), 128'(ras_len));
            chk("row", 128'(adr[k][27:9]), 128'(st_row));
            chk("bus_clk", 128'h1, 128'(st_bc));
        end
    endtask
    // a word on the low half of a 32-bit port must strobe only the low lanes
    task automatic t_lanes();
        reg_wr(DRC_OFS_BANKCFG, 32'h24);
        access(28'h8000026, 1'b1, DRC_SZ_WORD, {16'h5566, 112'h0});
        chk("cas_lanes", 128'h3, 128'(ack_cas));
        chk("wdata", 128'h55665566, 128'(wq[0]));
        access(28'h8000026, 1'b0, DRC_SZ_WORD, 128'h0);
        chk("cas_lanes", 128'h3, 128'(ack_cas));
        chk("rdata", 128'h5566, 128'(rd[15:0]));
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_write_long();
        t_read_word();
        t_edo();
        t_beats();
        t_lanes();
        end_of_test();
    end
endmodule

/* File: tb/drc_dram_model.sv */
// partner model: a small fast-page or edo dram on the controller pins
// assumes a 16-word array indexed by the low column bits only
module drc_dram_model
    import drc_pkg::*;
(
    input wire logic clk,
    input wire logic edo,
    input wire drc_pins_s dram,
    output logic [31:0] dram_din
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [16];
    logic [3:0] idx;
    assign idx = dram.addr[3:0];
    initial begin
        dram_din = 32'h0;
        for (int i = 0; i < 16; i++) mem[i] = 32'h5a3c0000 | 32'(i);
    end
    // ==========================================================
    // released bus toggles unless edo is set and ras is low, so a late fast-page sample never looks valid
    always @(posedge clk) begin
        if (dram.cas_n != 4'hf && !dram.dram_write_strobe_n) begin
            for (int i = 0; i < 4; i++)
                if (!dram.cas_n[i]) mem[idx][31 - 8 * i -: 8] <= dram.dout[31 - 8 * i -: 8];
        end else if (dram.cas_n != 4'hf) dram_din <= mem[idx];
        else if (!(edo && dram.ras_n != 2'h3)) dram_din <= ~dram_din;
    end
endmodule
